// file: pcu_defs.svh
// Address map, field positions and reset values of the position capture unit
`ifndef PCU_DEFS_SVH
`define PCU_DEFS_SVH

// ----------------------------------------------------------------
// Register word addresses
// ----------------------------------------------------------------
`define PCU_ADDR_STATUS     16'h0A02
`define PCU_ADDR_EDGE_ONE   16'h0A04
`define PCU_ADDR_EDGE_TWO   16'h0A06
`define PCU_ADDR_RUN_ONE    16'h0A08
`define PCU_ADDR_RUN_TWO    16'h0A0A
`define PCU_ADDR_POSH_ONE   16'h0A0C
`define PCU_ADDR_POSL_ONE   16'h0A0D
`define PCU_ADDR_POSH_TWO   16'h0A0E
`define PCU_ADDR_POSL_TWO   16'h0A0F
`define PCU_ADDR_COUNT_ONE  16'h0A10
`define PCU_ADDR_COUNT_TWO  16'h0A12

// ----------------------------------------------------------------
// Fields and limits
// ----------------------------------------------------------------
`define PCU_FLAG_ONE_BIT    0
`define PCU_FLAG_TWO_BIT    1
`define PCU_RUN_MAX         16'h0002
`define PCU_EDGE_MAX        16'h0001
`define PCU_EDGE_RISING     1'b1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PCU_EDGE_RESET      1'b0
`define PCU_COUNT_RESET     16'h0000
`define PCU_POS_RESET       32'h0000_0000
`define PCU_DATA_RESET      16'h0000
`define PCU_COUNT_ONE       16'h0001

`endif

// file: pcu_pkg.sv
// Types shared by the position capture unit modules
package pcu_pkg;

	typedef enum logic [1:0]
	{
		PCU_STOP = 2'b00,
		PCU_ONCE = 2'b01,
		PCU_CONT = 2'b10
	} pcu_run_type;

	typedef enum logic [3:0]
	{
		PCU_SEL_NONE      = 4'b0000,
		PCU_SEL_STATUS    = 4'b0001,
		PCU_SEL_EDGE_ONE  = 4'b0010,
		PCU_SEL_EDGE_TWO  = 4'b0011,
		PCU_SEL_RUN_ONE   = 4'b0100,
		PCU_SEL_RUN_TWO   = 4'b0101,
		PCU_SEL_POSH_ONE  = 4'b0110,
		PCU_SEL_POSL_ONE  = 4'b0111,
		PCU_SEL_POSH_TWO  = 4'b1000,
		PCU_SEL_POSL_TWO  = 4'b1001,
		PCU_SEL_COUNT_ONE = 4'b1010,
		PCU_SEL_COUNT_TWO = 4'b1011
	} pcu_sel_type;

endpackage

// file: pcu_sync.sv
// Trigger pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module pcu_sync
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic s1;
	logic s2;
	logic s3;
	logic primed;
	logic agree;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign agree = (s2 == s3);

	// First agreement after reset only primes the level, but it compares the
	// reset zeros of s2 and s3, so a pin already high at reset still gives a rising edge
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			primed <= 1'b0;
			level  <= 1'b0;
			rise   <= 1'b0;
			fall   <= 1'b0;
		end
		else
		begin
			rise <= primed && agree && s3 && !level;
			fall <= primed && agree && !s3 && level;
			if (agree)
			begin
				primed <= 1'b1;
				level  <= s3;
			end
		end
	end
endmodule

// file: pcu_channel.sv
// One capture channel: run mode, edge qualification, event tally and latch
`timescale 1ns/1ps
module pcu_channel
	import pcu_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         rise,
	input  wire logic         fall,
	input  wire logic         edge_sel,
	input  wire logic         cmd_valid,
	input  wire pcu_pkg::pcu_run_type cmd_mode,
	input  wire logic [31:0]  position,
	input  wire logic         shift_valid,
	input  wire logic [31:0]  shift,
	output pcu_pkg::pcu_run_type mode,
	output logic [15:0]       count,
	output logic [31:0]       latch,
	output logic              hit
);
	`include "pcu_defs.svh"

	logic activate;
	logic trig;

	assign trig = (edge_sel == `PCU_EDGE_RISING) ? rise : fall;
	assign hit = trig && (mode != PCU_STOP);
	assign activate = cmd_valid && (cmd_mode != PCU_STOP);

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			mode <= PCU_STOP;
		else if (cmd_valid)
			mode <= cmd_mode;
		else if (hit && mode == PCU_ONCE)
			mode <= PCU_STOP;
		else
			mode <= mode;
	end

	// tally cleared on activation, a coincident event still counts
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			count <= `PCU_COUNT_RESET;
		else if (activate)
			count <= hit ? `PCU_COUNT_ONE : `PCU_COUNT_RESET;
		else if (hit)
			count <= count + `PCU_COUNT_ONE;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			latch <= `PCU_POS_RESET;
		else if (hit)
			latch <= position;
		else if (shift_valid)
			latch <= latch + shift;
	end
endmodule

// file: pcu_capture_unit.sv
// Position capture unit top: register port, status word and two channels
//
// Contract
// - Run control takes 0 stop, 1 single, 2 continuous; effective at once.
// - Single mode stops itself after the first latched position.
// - Continuous mode captures every qualifying edge until software cancels.
// - Edge select 0 means falling edge, 1 means rising edge.
// - Channel two edge select resets to 0, falling edge.
// - A 16-bit event tally increments on every capture.
// - The event tally clears whenever its channel is activated.
// - Each capture stores the signed 32-bit position, read only.
// - Stored positions are recomputed when the position reference is redefined.
// - Status word bit 0 flags input one, bit 1 flags input two.
// - Channel one mirrors channel two with its own registers.
`timescale 1ns/1ps
module pcu_capture_unit
	import pcu_pkg::*;
(
	input  wire logic        CLK,
	input  wire logic        RST_B,
	input  wire logic        TRIGGER_INPUT_ONE,
	input  wire logic        TRIGGER_INPUT_TWO,
	input  wire logic [31:0] POSITION,
	input  wire logic        REF_SHIFT_VALID,
	input  wire logic [31:0] REF_SHIFT,
	input  wire logic [15:0] REG_ADDR,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	input  wire logic [15:0] REG_WDATA,
	output logic      [15:0] REG_RDATA,
	output logic             REG_ACK,
	output logic             REG_ERR,
	output logic      [1:0]  CAPTURE_RUNNING
);
	import pcu_pkg::*;
	`include "pcu_defs.svh"

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Shared by the write and read paths so both see one map
	function automatic pcu_sel_type decode_addr(input logic [15:0] addr);
		pcu_sel_type sel;
		sel = PCU_SEL_NONE;
		case (addr)
			`PCU_ADDR_STATUS:    sel = PCU_SEL_STATUS;
			`PCU_ADDR_EDGE_ONE:  sel = PCU_SEL_EDGE_ONE;
			`PCU_ADDR_EDGE_TWO:  sel = PCU_SEL_EDGE_TWO;
			`PCU_ADDR_RUN_ONE:   sel = PCU_SEL_RUN_ONE;
			`PCU_ADDR_RUN_TWO:   sel = PCU_SEL_RUN_TWO;
			`PCU_ADDR_POSH_ONE:  sel = PCU_SEL_POSH_ONE;
			`PCU_ADDR_POSL_ONE:  sel = PCU_SEL_POSL_ONE;
			`PCU_ADDR_POSH_TWO:  sel = PCU_SEL_POSH_TWO;
			`PCU_ADDR_POSL_TWO:  sel = PCU_SEL_POSL_TWO;
			`PCU_ADDR_COUNT_ONE: sel = PCU_SEL_COUNT_ONE;
			`PCU_ADDR_COUNT_TWO: sel = PCU_SEL_COUNT_TWO;
			default:             sel = PCU_SEL_NONE;
		endcase
		return sel;
	endfunction

	// Register is read-only from the bus side
	function automatic logic is_read_only(input pcu_sel_type sel);
		logic ro;
		ro = 1'b0;
		case (sel)
			PCU_SEL_STATUS,
			PCU_SEL_POSH_ONE,
			PCU_SEL_POSL_ONE,
			PCU_SEL_POSH_TWO,
			PCU_SEL_POSL_TWO,
			PCU_SEL_COUNT_ONE,
			PCU_SEL_COUNT_TWO: ro = 1'b1;
			default:           ro = 1'b0;
		endcase
		return ro;
	endfunction

	// ----------------------------------------------------------------
	// Internal signals; the per-channel arrays use index 0 for input one
	// ----------------------------------------------------------------
	pcu_sel_type       sel;
	logic              wr_go;
	logic              rd_go;
	logic [1:0]        pin;
	logic [1:0]        level;
	logic [1:0]        rise;
	logic [1:0]        fall;
	logic [1:0]        edge_select;
	logic [1:0]        cmd_valid;
	pcu_run_type       cmd_mode;
	pcu_run_type       mode [2];
	logic [15:0]       count [2];
	logic [31:0]       latch [2];
	logic [1:0]        hit;
	logic [1:0]        done_flag;
	logic [15:0]       low_snap [2];
	logic [1:0]        edge_wr;
	logic [1:0]        run_wr;
	logic              run_ok;
	logic              edge_ok;
	logic [15:0]       next_rdata;
	logic              next_err;

	assign sel      = decode_addr(REG_ADDR);
	// Write wins when both strobes arrive together
	assign wr_go    = REG_WR;
	assign rd_go    = REG_RD && !REG_WR;
	assign pin[0]   = TRIGGER_INPUT_ONE;
	assign pin[1]   = TRIGGER_INPUT_TWO;
	assign cmd_mode = pcu_run_type'(REG_WDATA[1:0]);

	assign run_ok  = (REG_WDATA <= `PCU_RUN_MAX);
	assign edge_ok = (REG_WDATA <= `PCU_EDGE_MAX);

	assign edge_wr[0] = wr_go && sel == PCU_SEL_EDGE_ONE && edge_ok;
	assign edge_wr[1] = wr_go && sel == PCU_SEL_EDGE_TWO && edge_ok;
	assign run_wr[0]  = wr_go && sel == PCU_SEL_RUN_ONE && run_ok;
	assign run_wr[1]  = wr_go && sel == PCU_SEL_RUN_TWO && run_ok;

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	// identical channel per input
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_chan
			pcu_sync u_sync
			(
				.clk   (CLK),
				.rst_b (RST_B),
				.pin   (pin[gi]),
				.level (level[gi]),
				.rise  (rise[gi]),
				.fall  (fall[gi])
			);

			assign cmd_valid[gi] = run_wr[gi];

			pcu_channel u_chan
			(
				.clk         (CLK),
				.rst_b       (RST_B),
				.rise        (rise[gi]),
				.fall        (fall[gi]),
				.edge_sel    (edge_select[gi]),
				.cmd_valid   (cmd_valid[gi]),
				.cmd_mode    (cmd_mode),
				.position    (POSITION),
				.shift_valid (REF_SHIFT_VALID),
				.shift       (REF_SHIFT),
				.mode        (mode[gi]),
				.count       (count[gi]),
				.latch       (latch[gi]),
				.hit         (hit[gi])
			);

			always_ff @(posedge CLK)
			begin
				if (!RST_B)
					edge_select[gi] <= `PCU_EDGE_RESET;
				else if (edge_wr[gi])
					edge_select[gi] <= REG_WDATA[0];
			end

			// sticky captured flag, set beats activation clear
			always_ff @(posedge CLK)
			begin
				if (!RST_B)
					done_flag[gi] <= 1'b0;
				else if (hit[gi])
					done_flag[gi] <= 1'b1;
				else if (run_wr[gi] && cmd_mode != PCU_STOP)
					done_flag[gi] <= 1'b0;
			end

			// Low word frozen when the high word is read, so a 32-bit
			// read in two accesses cannot tear across a capture
			always_ff @(posedge CLK)
			begin
				if (!RST_B)
					low_snap[gi] <= `PCU_DATA_RESET;
				else if (rd_go && sel == (gi == 0 ? PCU_SEL_POSH_ONE : PCU_SEL_POSH_TWO))
					low_snap[gi] <= latch[gi][15:0];
			end

			always_ff @(posedge CLK)
			begin
				if (!RST_B)
					CAPTURE_RUNNING[gi] <= 1'b0;
				else
					CAPTURE_RUNNING[gi] <= (mode[gi] != PCU_STOP);
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read data and error answer
	// ----------------------------------------------------------------
	always_comb
	begin
		next_rdata = `PCU_DATA_RESET;
		next_err   = 1'b0;
		if (wr_go)
		begin
			case (sel)
				PCU_SEL_EDGE_ONE,
				PCU_SEL_EDGE_TWO: next_err = !edge_ok;
				PCU_SEL_RUN_ONE,
				PCU_SEL_RUN_TWO:  next_err = !run_ok;
				PCU_SEL_NONE:     next_err = 1'b1;
				default:          next_err = is_read_only(sel);
			endcase
		end
		else if (rd_go)
		begin
			case (sel)
				PCU_SEL_STATUS:
				begin
					next_rdata[`PCU_FLAG_ONE_BIT] = done_flag[0];
					next_rdata[`PCU_FLAG_TWO_BIT] = done_flag[1];
				end
				PCU_SEL_EDGE_ONE:  next_rdata[0] = edge_select[0];
				PCU_SEL_EDGE_TWO:  next_rdata[0] = edge_select[1];
				PCU_SEL_RUN_ONE:   next_rdata[1:0] = mode[0];
				PCU_SEL_RUN_TWO:   next_rdata[1:0] = mode[1];
				PCU_SEL_POSH_ONE:  next_rdata = latch[0][31:16];
				PCU_SEL_POSL_ONE:  next_rdata = low_snap[0];
				PCU_SEL_POSH_TWO:  next_rdata = latch[1][31:16];
				PCU_SEL_POSL_TWO:  next_rdata = low_snap[1];
				PCU_SEL_COUNT_ONE: next_rdata = count[0];
				PCU_SEL_COUNT_TWO: next_rdata = count[1];
				default:           next_err = 1'b1;
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			REG_RDATA <= `PCU_DATA_RESET;
			REG_ACK   <= 1'b0;
			REG_ERR   <= 1'b0;
		end
		else
		begin
			REG_RDATA <= next_rdata;
			REG_ACK   <= wr_go || rd_go;
			REG_ERR   <= next_err;
		end
	end
endmodule

// file: pcu_capture_unit_checker.sv
// Port assertions for the position capture unit
`timescale 1ns/1ps
module pcu_capture_unit_checker
(
	input wire logic        CLK,
	input wire logic        RST_B,
	input wire logic [15:0] REG_ADDR,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [15:0] REG_WDATA,
	input wire logic [15:0] REG_RDATA,
	input wire logic        REG_ACK,
	input wire logic        REG_ERR,
	input wire logic [1:0]  CAPTURE_RUNNING
);
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (!RST_B);
	sequence run_set(a);
		REG_WR && REG_ADDR == a && REG_WDATA inside {16'h0001, 16'h0002};
	endsequence
	sequence run_clr(a);
		REG_WR && REG_ADDR == a && REG_WDATA == 16'h0000;
	endsequence
	ack_follows_a: assert property ((REG_WR || REG_RD) |=> REG_ACK)
		else $error("access not answered");
	ack_single_a: assert property (!(REG_WR || REG_RD) |=> !REG_ACK)
		else $error("answer without access");
	err_with_ack_a: assert property (REG_ERR |-> REG_ACK)
		else $error("error flag without answer");
	run_range_a: assert property (REG_WR && REG_ADDR == 16'h0A0A && REG_WDATA > 16'h0002 |=> REG_ERR)
		else $error("run value not refused");
	edge_range_a: assert property (REG_WR && REG_ADDR == 16'h0A06 && REG_WDATA > 16'h0001 |=> REG_ERR)
		else $error("edge value not refused");
	ro_write_a: assert property (REG_WR && REG_ADDR inside {16'h0A0E, 16'h0A0F, 16'h0A12} |=> REG_ERR)
		else $error("read-only write accepted");
	status_bits_a: assert property (REG_RD && !REG_WR && REG_ADDR == 16'h0A02 |=> REG_RDATA[15:2] == 14'h0)
		else $error("status upper bits set");
	// Running flag lags the mode by one cycle
	start_two_a: assert property (run_set(16'h0A0A) |=> !REG_ERR ##1 CAPTURE_RUNNING[1])
		else $error("channel two not started");
	stop_two_a: assert property (run_clr(16'h0A0A) |=> ##1 !CAPTURE_RUNNING[1])
		else $error("channel two not stopped");
	start_one_a: assert property (run_set(16'h0A08) |=> !REG_ERR ##1 CAPTURE_RUNNING[0])
		else $error("channel one not started");
endmodule

bind pcu_capture_unit pcu_capture_unit_checker chk
(
	.CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .REG_ERR(REG_ERR),
	.CAPTURE_RUNNING(CAPTURE_RUNNING)
);

// file: pcu_trig_model.sv
// External trigger source on one capture pin
`timescale 1ns/1ps
module pcu_trig_model
(
	input  wire logic want,
	input  wire logic slow,
	output logic      pin
);
	initial pin = 1'b0;
	// Moves off the clock edge, as an unrelated source would
	always @(want) pin <= #(slow ? 7 : 3) want;
endmodule

// file: position_capture_unit_tb.sv
// Self-checking bench for the position capture unit
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("mismatch at %0t: %h vs %h", $time, g, e); end end
module position_capture_unit_tb;
	logic        CLK = 1'b0;
	logic        RST_B = 1'b0;
	logic [1:0]  want = 2'b00;
	logic [1:0]  pins;
	logic [31:0] POSITION = 32'h0, REF_SHIFT = 32'h0;
	logic        REF_SHIFT_VALID = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
	logic [15:0] REG_ADDR = 16'h0, REG_WDATA = 16'h0, REG_RDATA, rnd = 16'h0010;
	logic        REG_ACK, REG_ERR;
	logic [1:0]  CAPTURE_RUNNING, m_flag = 2'b00;
	logic [31:0] m_latch [2] = '{32'h0, 32'h0};
	int          m_tally [2] = '{0, 0}, m_mode [2] = '{0, 0};
	int          failures = 0, checked = 0, cycles = 0;

	pcu_trig_model trig_one (.want(want[0]), .slow(1'b0), .pin(pins[0]));
	pcu_trig_model trig_two (.want(want[1]), .slow(1'b1), .pin(pins[1]));
	pcu_capture_unit DUT
	(
		.CLK(CLK), .RST_B(RST_B), .TRIGGER_INPUT_ONE(pins[0]), .TRIGGER_INPUT_TWO(pins[1]),
		.POSITION(POSITION), .REF_SHIFT_VALID(REF_SHIFT_VALID), .REF_SHIFT(REF_SHIFT),
		.REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK), .REG_ERR(REG_ERR),
		.CAPTURE_RUNNING(CAPTURE_RUNNING)
	);

	initial forever #5 CLK = ~CLK;
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			end_of_test();
		end
	end

	function automatic logic [15:0] lfsr_step(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	// ---------------------------------------------
	// Bus and pin tasks
	// ---------------------------------------------
	task automatic acc(input logic w, input int a, input int d, input int ex, input logic er);
		@(posedge CLK);
		REG_ADDR <= a[15:0];
		REG_WDATA <= d[15:0];
		REG_WR <= w;
		REG_RD <= !w;
		@(posedge CLK);
		REG_WR <= 1'b0;
		REG_RD <= 1'b0;
		#1;
		`CHK(REG_ACK, 1'b1)
		`CHK(REG_ERR, er)
		`CHK(REG_RDATA, ex[15:0])
	endtask

	task automatic run(input int ch, input int m);
		acc(1'b1, 'hA08 + 2 * ch, m, 0, 1'b0);
		m_mode[ch] = m;
		if (m != 0)
		begin
			m_tally[ch] = 0;
			m_flag[ch] = 1'b0;
		end
	endtask

	task automatic pin_to(input int ch, input logic v);
		@(posedge CLK);
		want[ch] <= v;
		repeat (10) @(posedge CLK);
	endtask

	task automatic capture(input int ch, input logic e);
		rnd = lfsr_step(rnd);
		@(posedge CLK);
		POSITION <= {rnd, ~rnd};
		pin_to(ch, !e);
		pin_to(ch, e);
		if (m_mode[ch] != 0)
		begin
			m_latch[ch] = {rnd, ~rnd};
			m_tally[ch] = (m_tally[ch] + 1) % 65536;
			m_flag[ch] = 1'b1;
			if (m_mode[ch] == 1)
				m_mode[ch] = 0;
		end
	endtask

	task automatic shift();
		rnd = lfsr_step(rnd);
		@(posedge CLK);
		REF_SHIFT <= {~rnd, rnd};
		REF_SHIFT_VALID <= 1'b1;
		@(posedge CLK);
		REF_SHIFT_VALID <= 1'b0;
		m_latch[0] = m_latch[0] + {~rnd, rnd};
		m_latch[1] = m_latch[1] + {~rnd, rnd};
	endtask

	task automatic check(input int ch);
		acc(1'b0, 'hA02, 0, {14'h0, m_flag}, 1'b0);
		acc(1'b0, 'hA10 + 2 * ch, 0, m_tally[ch], 1'b0);
		acc(1'b0, 'hA0C + 2 * ch, 0, m_latch[ch][31:16], 1'b0);
		acc(1'b0, 'hA0D + 2 * ch, 0, m_latch[ch][15:0], 1'b0);
		acc(1'b0, 'hA08 + 2 * ch, 0, m_mode[ch], 1'b0);
		`CHK(CAPTURE_RUNNING[ch], m_mode[ch] != 0)
	endtask

	task automatic end_of_test();
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial
	begin
		repeat (12) @(posedge CLK);
		RST_B <= 1'b1;
		acc(1'b0, 'hA06, 0, 0, 1'b0);
		acc(1'b0, 'hA00, 0, 0, 1'b1);
		acc(1'b1, 'hA0A, 3, 0, 1'b1);
		acc(1'b1, 'hA06, 2, 0, 1'b1);
		acc(1'b1, 'hA02, 1, 0, 1'b1);
		acc(1'b0, 'hA0A, 0, 0, 1'b0);
		for (int ch = 0; ch < 2; ch++)
			for (int e = 0; e < 2; e++)
			begin
				acc(1'b1, 'hA04 + 2 * ch, e, 0, 1'b0);
				pin_to(ch, e == 0);
				run(ch, 1);
				check(ch);
				capture(ch, e[0]);
				capture(ch, e[0]);
				check(ch);
				run(ch, 2);
				capture(ch, e[0]);
				capture(ch, e[0]);
				check(ch);
				shift();
				check(ch);
				run(ch, 0);
				capture(ch, e[0]);
				check(ch);
			end
		end_of_test();
	end
endmodule
